// file: scd_pkg.sv
// constants and types shared by the sysref delay calibration block
// assumes a single device clock domain and an 8/24-bit register port
package scd_pkg;

   // ==========================================================
   // register offsets and reset values
   localparam logic [11:0] EN_OFS         = 12'h2b0;
   localparam logic [11:0] CFG_OFS        = 12'h2b1;
   localparam logic [11:0] STATUS_OFS     = 12'h2b2;
   localparam logic [11:0] MANUAL_OFS     = 12'h2b5;
   localparam logic [7:0]  EN_RESET       = 8'h00;
   localparam logic [7:0]  CFG_RESET      = 8'h05;
   localparam logic [23:0] MANUAL_RESET   = 24'h000000;

   // ==========================================================
   // field positions
   localparam int EN_BIT        = 0;
   localparam int AVG_LSB       = 2;
   localparam int ACC_LSB       = 0;
   localparam int DONE_BIT      = 17;
   localparam int WORD_W        = 17;

   // ==========================================================
   // timing: time bound base and per-setting tables, all in device clock cycles
   localparam int CAL_BOUND_BASE = 384 * 19;
   // index 0 is the leftmost element, so the tables run from the shortest setting up
   localparam logic [15:0] MAX_PERIOD [4] = '{16'h0080, 16'h0680, 16'h1e80, 16'h7e80};
   localparam logic [8:0]  ACC_CYCLES [4] = '{9'h004, 9'h010, 9'h040, 9'h100};

   // ==========================================================
   // types
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [23:0] wdata;
   } scd_reg_req_type;

   typedef struct packed {
      logic       clock_invert;
      logic [7:0] coarse;
      logic [7:0] fine;
   } scd_delay_type;

   typedef enum logic [4:0] {
      CAL_IDLE = 5'h01,
      CAL_ARM  = 5'h02,
      CAL_MEAS = 5'h04,
      CAL_DONE = 5'h08,
      CAL_FAIL = 5'h10
   } scd_state_type;

endpackage : scd_pkg

// file: scd_sysref_timer.sv
// sysref pin synchroniser and edge-to-edge timer
// assumes sysref is asynchronous to clk; results are latched on each rising edge
`timescale 1ns/1ns
module scd_sysref_timer (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        sysref_pin,
   input  wire logic [8:0]  win_len,
   output logic             edge_r,
   output logic [15:0]      period_r,
   output logic [8:0]       high_cnt_r,
   output logic [15:0]      since_r
);

   // ==========================================================
   // synchroniser and counters
   logic        sync1_r, sync2_r, prev_r;
   logic        rise;
   logic [15:0] since_nxt;
   logic [8:0]  high_acc_r, high_acc_nxt;

   // sync1_r is read only by sync2_r
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= sysref_pin;
         sync2_r <= sync1_r;
      end
   end

   assign rise = sync2_r & ~prev_r;

   always_comb begin
      high_acc_nxt = high_acc_r;
      // saturate so an absent sysref reads as a very long period
      since_nxt = (since_r == 16'hffff) ? since_r : since_r + 16'h0001;
      if (rise) begin
         since_nxt    = 16'h0001;
         high_acc_nxt = 9'h001;
      end else if (sync2_r && ({7'h00, since_r} < win_len) && high_acc_r != 9'h1ff) begin
         high_acc_nxt = high_acc_r + 9'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_r     <= 1'b0;
         edge_r     <= 1'b0;
         since_r    <= 16'h0000;
         period_r   <= 16'h0000;
         high_cnt_r <= 9'h000;
         high_acc_r <= 9'h000;
      end else begin
         prev_r     <= sync2_r;
         edge_r     <= rise;
         since_r    <= since_nxt;
         high_acc_r <= high_acc_nxt;
         if (rise) begin
            period_r   <= since_r;
            high_cnt_r <= high_acc_r;
         end
      end
   end

endmodule : scd_sysref_timer

// file: scd_cal.sv
// sysref delay calibration: registers, calibration sequencer and delay select
// assumes register requests arrive decoded from the serial port on clk
//
// How it works
// - with calibration disabled the delay output follows the manual delay register, the reset default.
// - with calibration enabled the delay comes from calibration and the manual register is ignored.
// - a sequence starts only on a 0-to-1 change of the enable bit.
// - config bits 3:2 pick 4, 16, 64 or 256 averages.
// - config bits 1:0 pick 4/16/64/256 cycles per accumulation and a 128/1664/7808/32384 cycle period limit.
// - calibration ends within 384*19*4^(avg+acc+2) device clocks.
// - status bit 17 reads 1 only while enabled and after the sequence has finished.
// - status bits 16:0 return the calibrated delay word, valid only with bit 17 set.
// - word bit 16 is clock inversion, bits 15:8 coarse, bits 7:0 fine.
// - the manual register uses the same inversion, coarse and fine layout.
`timescale 1ns/1ns
module scd_cal #(
   parameter int CAL_BOUND_BASE = scd_pkg::CAL_BOUND_BASE
) (
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   input  wire scd_pkg::scd_reg_req_type reg_req,
   input  wire logic                     sysref_pin,
   output logic [23:0]                   reg_rdata_r,
   output scd_pkg::scd_delay_type        delay_out_r,
   output logic                          cal_failed_r
);

   // ==========================================================
   // register file
   logic [7:0]  en_reg_r, en_reg_nxt;
   logic [7:0]  cfg_reg_r, cfg_reg_nxt;
   logic [23:0] manual_r, manual_nxt;
   logic [23:0] rdata_nxt;
   logic        cal_en_r, cal_en_nxt;
   logic [1:0]  avg_sel, acc_sel;

   assign cal_en_r   = en_reg_r[scd_pkg::EN_BIT];
   assign cal_en_nxt = en_reg_nxt[scd_pkg::EN_BIT];
   assign avg_sel    = cfg_reg_r[scd_pkg::AVG_LSB +: 2];
   assign acc_sel    = cfg_reg_r[scd_pkg::ACC_LSB +: 2];

   // ==========================================================
   // sequencer state
   scd_pkg::scd_state_type state_r, state_nxt;
   logic [8:0]   avg_cnt_r, avg_cnt_nxt;
   logic [23:0]  period_sum_r, period_sum_nxt;
   logic [16:0]  high_sum_r, high_sum_nxt;
   logic [29:0]  watch_r, watch_nxt;
   logic [16:0]  result_r, result_nxt;
   logic         done_r, done_nxt;
   logic         failed_nxt;
   logic [29:0]  cal_bound;
   logic [8:0]   avg_total;
   logic [4:0]   avg_shift;
   logic         edge_r;
   logic [15:0]  period_r, since_r;
   logic [8:0]   high_cnt_r;
   logic [23:0]  period_avg;
   logic [16:0]  high_avg;
   scd_pkg::scd_delay_type delay_nxt, manual_word;

   scd_sysref_timer u_timer (
      .clk        (clk),
      .rst_b      (rst_b),
      .sysref_pin (sysref_pin),
      .win_len    (scd_pkg::ACC_CYCLES[acc_sel]),
      .edge_r     (edge_r),
      .period_r   (period_r),
      .high_cnt_r (high_cnt_r),
      .since_r    (since_r)
   );

   always_comb begin
      en_reg_nxt  = en_reg_r;
      cfg_reg_nxt = cfg_reg_r;
      manual_nxt  = manual_r;
      rdata_nxt   = reg_rdata_r;
      if (reg_req.wr) begin
         case (reg_req.addr)
            scd_pkg::EN_OFS:     en_reg_nxt  = reg_req.wdata[7:0];
            scd_pkg::CFG_OFS:    cfg_reg_nxt = reg_req.wdata[7:0];
            scd_pkg::MANUAL_OFS: manual_nxt  = reg_req.wdata;
            default: ;
         endcase
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            scd_pkg::EN_OFS:     rdata_nxt = {16'h0000, en_reg_r};
            scd_pkg::CFG_OFS:    rdata_nxt = {16'h0000, cfg_reg_r};
            scd_pkg::STATUS_OFS: rdata_nxt = {6'h00, done_r, result_r};
            scd_pkg::MANUAL_OFS: rdata_nxt = manual_r;
            default:             rdata_nxt = 24'h000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_reg_r    <= scd_pkg::EN_RESET;
         cfg_reg_r   <= scd_pkg::CFG_RESET;
         manual_r    <= scd_pkg::MANUAL_RESET;
         reg_rdata_r <= 24'h000000;
      end else begin
         en_reg_r    <= en_reg_nxt;
         cfg_reg_r   <= cfg_reg_nxt;
         manual_r    <= manual_nxt;
         reg_rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // calibration sequencer
   // each average measures one sysref period and the high time inside the
   // accumulation window; more averages trade run time for lower variance
   assign avg_shift  = {2'b00, avg_sel, 1'b0} + 5'h02;
   assign avg_total  = 9'(9'h004 << {avg_sel, 1'b0});
   // the exponent reaches 16, so the shift amount needs five bits
   assign cal_bound  = 30'(CAL_BOUND_BASE) << ({2'b00, avg_sel, 1'b0} + {2'b00, acc_sel, 1'b0} + 5'h04);
   assign period_avg = period_sum_r >> avg_shift;
   assign high_avg   = high_sum_r >> avg_shift;

   always_comb begin
      state_nxt      = state_r;
      avg_cnt_nxt    = avg_cnt_r;
      period_sum_nxt = period_sum_r;
      high_sum_nxt   = high_sum_r;
      result_nxt     = result_r;
      failed_nxt     = cal_failed_r;
      watch_nxt      = (watch_r == 30'h3fffffff) ? watch_r : watch_r + 30'h00000001;
      case (state_r)
         scd_pkg::CAL_IDLE: begin
            if (cal_en_nxt && !cal_en_r) begin
               state_nxt      = scd_pkg::CAL_ARM;
               avg_cnt_nxt    = 9'h000;
               period_sum_nxt = 24'h000000;
               high_sum_nxt   = 17'h00000;
               watch_nxt      = 30'h00000000;
               failed_nxt     = 1'b0;
            end
         end
         scd_pkg::CAL_ARM, scd_pkg::CAL_MEAS: begin
            if (since_r > scd_pkg::MAX_PERIOD[acc_sel] || watch_r >= cal_bound - 30'h2) begin
               state_nxt  = scd_pkg::CAL_FAIL;
               failed_nxt = 1'b1;
            end else if (edge_r && state_r == scd_pkg::CAL_ARM) begin
               state_nxt = scd_pkg::CAL_MEAS;
            end else if (edge_r) begin
               period_sum_nxt = period_sum_r + {8'h00, period_r};
               high_sum_nxt   = high_sum_r + {8'h00, high_cnt_r};
               avg_cnt_nxt    = avg_cnt_r + 9'h001;
               if (avg_cnt_nxt == avg_total)
                  state_nxt = scd_pkg::CAL_DONE;
            end
         end
         scd_pkg::CAL_DONE: begin
            result_nxt = {period_avg[8], period_avg[7:0], high_avg[7:0]};
         end
         scd_pkg::CAL_FAIL: ;
         default: state_nxt = scd_pkg::CAL_IDLE;
      endcase
      if (!cal_en_nxt)
         state_nxt = scd_pkg::CAL_IDLE;
      // the word loads at the end of the first cycle of CAL_DONE, on the same edge as the flag,
      // so a reader never sees the flag beside a stale word
      done_nxt = (state_r == scd_pkg::CAL_DONE) && (state_nxt == scd_pkg::CAL_DONE) && cal_en_nxt;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r      <= scd_pkg::CAL_IDLE;
         avg_cnt_r    <= 9'h000;
         period_sum_r <= 24'h000000;
         high_sum_r   <= 17'h00000;
         watch_r      <= 30'h00000000;
         result_r     <= 17'h00000;
         done_r       <= 1'b0;
         cal_failed_r <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         avg_cnt_r    <= avg_cnt_nxt;
         period_sum_r <= period_sum_nxt;
         high_sum_r   <= high_sum_nxt;
         watch_r      <= watch_nxt;
         result_r     <= result_nxt;
         done_r       <= done_nxt;
         cal_failed_r <= failed_nxt;
      end
   end

   // ==========================================================
   // delay select
   assign manual_word = scd_pkg::scd_delay_type'(manual_r[16:0]);

   always_comb begin
      if (cal_en_r)
         delay_nxt = scd_pkg::scd_delay_type'(result_r);
      else
         delay_nxt = manual_word;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         delay_out_r <= '0;
      else
         delay_out_r <= delay_nxt;
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // cycles since the sequence left idle, counted apart from watch_r so the time
   // bound is not judged only by the counter that enforces it
   logic [29:0] chk_run_cnt_r, chk_run_cnt_nxt;

   always_comb begin
      chk_run_cnt_nxt = chk_run_cnt_r;
      if (state_r == scd_pkg::CAL_IDLE)
         chk_run_cnt_nxt = 30'h00000000;
      else if ((state_r == scd_pkg::CAL_ARM || state_r == scd_pkg::CAL_MEAS) && chk_run_cnt_r != 30'h3fffffff)
         chk_run_cnt_nxt = chk_run_cnt_r + 30'h00000001;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         chk_run_cnt_r <= 30'h00000000;
      else
         chk_run_cnt_r <= chk_run_cnt_nxt;
   end

   // ==========================================================
   // register port and delay select checks
   chk_manual_drives_out: assert property (!cal_en_r |=> delay_out_r == $past(manual_r[16:0]))
      else $error("manual delay not driven while calibration is off");
   chk_manual_ignored: assert property (cal_en_r |=> delay_out_r == $past(result_r))
      else $error("delay output not taken from calibration");
   chk_manual_layout: assert property (!cal_en_r |=> delay_out_r.clock_invert == $past(manual_r[16])
      && delay_out_r.coarse == $past(manual_r[15:8]) && delay_out_r.fine == $past(manual_r[7:0]))
      else $error("manual delay fields not mapped to the output");
   chk_en_write: assert property (reg_req.wr && reg_req.addr == scd_pkg::EN_OFS
      |=> en_reg_r == $past(reg_req.wdata[7:0]))
      else $error("enable register write lost");
   chk_cfg_write: assert property (reg_req.wr && reg_req.addr == scd_pkg::CFG_OFS
      |=> cfg_reg_r == $past(reg_req.wdata[7:0]))
      else $error("configuration register write lost");
   chk_manual_write: assert property (reg_req.wr && reg_req.addr == scd_pkg::MANUAL_OFS
      |=> manual_r == $past(reg_req.wdata))
      else $error("manual delay register write lost");
   chk_done_readback: assert property (reg_req.rd && reg_req.addr == scd_pkg::STATUS_OFS
      |=> reg_rdata_r[scd_pkg::DONE_BIT] == $past(done_r) && reg_rdata_r[16:0] == $past(result_r))
      else $error("status readback mismatch");

   // ==========================================================
   // sequencer checks
   chk_start_on_rise: assert property ($rose(state_r == scd_pkg::CAL_ARM) |-> $rose(cal_en_r))
      else $error("calibration started without enable rising");
   chk_start_cleared: assert property ($rose(state_r == scd_pkg::CAL_ARM)
      |-> avg_cnt_r == 9'h000 && !cal_failed_r)
      else $error("sequence started with stale count or failure flag");
   chk_avg_count: assert property ($rose(state_r == scd_pkg::CAL_DONE) |-> avg_cnt_r == avg_total)
      else $error("wrong number of averages");
   chk_window_len: assert property (edge_r && state_r == scd_pkg::CAL_MEAS
      |-> high_cnt_r <= scd_pkg::ACC_CYCLES[acc_sel])
      else $error("high count longer than the accumulation window");
   chk_period_limit: assert property ((state_r == scd_pkg::CAL_ARM || state_r == scd_pkg::CAL_MEAS)
      && since_r > scd_pkg::MAX_PERIOD[acc_sel] && cal_en_nxt |=> state_r == scd_pkg::CAL_FAIL)
      else $error("overlong sysref period not failed");
   chk_time_bound: assert property ((state_r == scd_pkg::CAL_ARM || state_r == scd_pkg::CAL_MEAS)
      |-> watch_r < cal_bound)
      else $error("calibration exceeded its time bound");
   chk_run_length: assert property ((state_r == scd_pkg::CAL_ARM || state_r == scd_pkg::CAL_MEAS)
      |-> chk_run_cnt_r < cal_bound)
      else $error("sequence ran past its time bound");
   chk_done_needs_en: assert property (done_r |-> cal_en_r && state_r == scd_pkg::CAL_DONE)
      else $error("done flag without enable and finished sequence");
   chk_idle_no_done: assert property (!cal_en_r |-> !done_r)
      else $error("done flag while calibration is off");
   chk_abort_to_idle: assert property (!cal_en_nxt |=> state_r == scd_pkg::CAL_IDLE)
      else $error("sequence not stopped when enable cleared");
   chk_result_held: assert property (done_r && $past(done_r) |-> $stable(result_r))
      else $error("delay word changed while reported done");
   chk_fail_no_done: assert property (state_r == scd_pkg::CAL_FAIL |-> !done_r)
      else $error("done flag set after failure");
   chk_fail_flagged: assert property ($rose(state_r == scd_pkg::CAL_FAIL) |-> cal_failed_r)
      else $error("failure not flagged");

   // ==========================================================
   // cover points
   cov_cal_done: cover property ($rose(done_r));
   cov_cal_fail: cover property ($rose(cal_failed_r));
   cov_abort: cover property (state_r == scd_pkg::CAL_MEAS ##1 state_r == scd_pkg::CAL_IDLE);
   cov_manual_mode: cover property (!cal_en_r && delay_out_r != '0);
   cov_long_cfg: cover property ($rose(done_r) && avg_sel == 2'h1 && acc_sel == 2'h1);

endmodule : scd_cal

// file: scd_sysref_src.sv
// behavioural sysref source: periodic pulse train timed in device clocks
// assumes the bench sets period and high time while run is low
`timescale 1ns/1ns
module scd_sysref_src (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        run,
   input  wire logic [15:0] period,
   input  wire logic [15:0] high_time,
   output logic             sysref
);
   logic [15:0] cnt_r;

   // ==========================================================
   // pulse generator
   // the period is whatever the bench asks for, so a too-long period is only sent on purpose
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r  <= 16'h0000;
         sysref <= 1'b0;
      end else if (!run) begin
         // held low between bursts so no stray edge starts an average
         cnt_r  <= 16'h0000;
         sysref <= 1'b0;
      end else begin
         cnt_r  <= (cnt_r == period - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
         sysref <= (cnt_r < high_time);
      end
   end
endmodule : scd_sysref_src

// file: sysref_delay_calibration_test.sv
// self-checking bench for the sysref delay calibration block
// assumes the calibration time base is shortened through CAL_BOUND_BASE
`timescale 1ns/1ns
module sysref_delay_calibration_test;
   localparam int BASE = 128;
   logic                     clk;
   logic                     rst_b;
   scd_pkg::scd_reg_req_type reg_req;
   logic                     sysref_pin;
   logic [23:0]              reg_rdata_r;
   scd_pkg::scd_delay_type   delay_out_r;
   logic                     cal_failed_r;
   logic                     run;
   logic [15:0]              period;
   logic [15:0]              high_time;
   int                       error_cnt;
   int                       checked;
   logic [23:0]              rd_val;

   scd_cal #(.CAL_BOUND_BASE(BASE)) DUT (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .sysref_pin(sysref_pin),
      .reg_rdata_r(reg_rdata_r), .delay_out_r(delay_out_r), .cal_failed_r(cal_failed_r));
   scd_sysref_src src (.clk(clk), .rst_b(rst_b), .run(run), .period(period), .high_time(high_time),
      .sysref(sysref_pin));

   // ==========================================================
   // clock, reset and bus tasks
   initial clk = 1'b0;
   always #50 clk = ~clk;

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic cmp_delay(input logic [16:0] exp);
      cmp({7'h00, delay_out_r}, {7'h00, exp}, "delay output");
   endtask : cmp_delay

   task automatic reg_wr(input logic [11:0] addr, input logic [23:0] data);
      @(posedge clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge clk);
      reg_req.wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : reg_wr

   task automatic reg_rd(input logic [11:0] addr, output logic [23:0] data);
      @(posedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 24'h000000};
      @(posedge clk);
      reg_req.rd <= 1'b0;
      #1;
      data = reg_rdata_r;
   endtask : reg_rd

   // polls the status register; a run past the time bound counts as a mismatch
   task automatic wait_done(input int bound);
      for (int i = 0; i < bound / 2; i++) begin
         reg_rd(scd_pkg::STATUS_OFS, rd_val);
         if (rd_val[scd_pkg::DONE_BIT] === 1'b1) begin
            reg_rd(scd_pkg::STATUS_OFS, rd_val);
            return;
         end
      end
      error_cnt++;
      $display("wrong value at %0t: calibration did not finish", $time);
      tally_and_finish();
   endtask : wait_done

   // ==========================================================
   // scenarios
   task automatic test_reset_values;
      reg_rd(scd_pkg::EN_OFS, rd_val);     cmp(rd_val, 24'h000000, "enable");
      reg_rd(scd_pkg::CFG_OFS, rd_val);    cmp(rd_val, 24'h000005, "config");
      reg_rd(scd_pkg::MANUAL_OFS, rd_val); cmp(rd_val, 24'h000000, "manual");
      reg_rd(scd_pkg::STATUS_OFS, rd_val); cmp(rd_val, 24'h000000, "status");
      cmp_delay(17'h00000);
      $display("test reset values done");
   endtask : test_reset_values

   task automatic test_manual;
      reg_wr(scd_pkg::MANUAL_OFS, 24'h01a53c);
      cmp_delay(17'h1a53c);
      reg_wr(scd_pkg::STATUS_OFS, 24'h03ffff);
      reg_rd(scd_pkg::STATUS_OFS, rd_val); cmp(rd_val, 24'h000000, "status ro");
      reg_rd(12'h2b3, rd_val);             cmp(rd_val, 24'h000000, "unmapped");
      $display("test manual delay done");
   endtask : test_manual

   // period 100 gives inversion 0 and coarse 0x64; the 4-cycle window lies inside the high time, so fine is 4
   task automatic test_cal_short;
      period <= 16'd100;
      high_time <= 16'd30;
      run <= 1'b1;
      reg_wr(scd_pkg::CFG_OFS, 24'h000000);
      reg_wr(scd_pkg::EN_OFS, 24'h000001);
      wait_done(BASE * 16 + 64);
      cmp({7'h00, rd_val[16:0]}, 24'h006404, "calibrated word");
      cmp_delay(rd_val[16:0]);
      reg_wr(scd_pkg::MANUAL_OFS, 24'h000777);
      cmp_delay(rd_val[16:0]);
      // a repeated write of 1 is no 0-to-1 change, so done must stay
      reg_wr(scd_pkg::EN_OFS, 24'h000001);
      reg_rd(scd_pkg::STATUS_OFS, rd_val); cmp({23'h0, rd_val[17]}, 24'h1, "done kept");
      reg_wr(scd_pkg::EN_OFS, 24'h000000);
      reg_rd(scd_pkg::STATUS_OFS, rd_val); cmp({23'h0, rd_val[17]}, 24'h0, "done off");
      cmp_delay(17'h00777);
      run <= 1'b0;
      $display("test short calibration done");
   endtask : test_cal_short

   // 16 averages of 16 cycles, period 1000 sets the inversion bit
   task automatic test_cal_long;
      period <= 16'd1000;
      high_time <= 16'd400;
      run <= 1'b1;
      reg_wr(scd_pkg::CFG_OFS, 24'h000005);
      reg_wr(scd_pkg::EN_OFS, 24'h000001);
      wait_done(BASE * 256 + 64);
      cmp({7'h00, rd_val[16:0]}, 24'h01e810, "calibrated word");
      cmp({23'h0, cal_failed_r}, 24'h0, "no failure");
      reg_wr(scd_pkg::EN_OFS, 24'h000000);
      run <= 1'b0;
      $display("test long calibration done");
   endtask : test_cal_long

   // period 200 is over the 128-cycle limit of the shortest accumulation
   task automatic test_cal_fail;
      int i;
      period <= 16'd200;
      high_time <= 16'd50;
      run <= 1'b1;
      reg_wr(scd_pkg::CFG_OFS, 24'h000000);
      reg_wr(scd_pkg::EN_OFS, 24'h000001);
      for (i = 0; i < BASE * 16 + 64 && cal_failed_r !== 1'b1; i++)
         @(posedge clk);
      #1;
      cmp({23'h0, cal_failed_r}, 24'h1, "failure flag");
      if (cal_failed_r !== 1'b1)
         tally_and_finish();
      reg_rd(scd_pkg::STATUS_OFS, rd_val); cmp({23'h0, rd_val[17]}, 24'h0, "done after fail");
      reg_wr(scd_pkg::EN_OFS, 24'h000000);
      run <= 1'b0;
      $display("test failed calibration done");
   endtask : test_cal_fail

   // ==========================================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      reg_req = '0;
      run = 1'b0;
      period = 16'd100;
      high_time = 16'd30;
      error_cnt = 0;
      checked = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);   // no register access until the block is out of reset
      test_reset_values();
      test_manual();
      test_cal_short();
      test_cal_fail();
      test_cal_long();
      tally_and_finish();
   end
endmodule : sysref_delay_calibration_test
